/* File: hw/pcbd_top.sv */
// Decoder from the shared host control bus to four user blocks.
`timescale 1ns/100ps
module pcbd_top (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [31:0] host_write_word,
  input  wire logic        host_strobe_n,
  output logic      [31:0] read_word,
  output logic             read_oe,
  output logic      [3:0]  wr_strobe,
  output logic      [3:0]  rd_strobe,
  output logic      [15:0] block_data,
  output logic      [5:0]  reg_select,
  output logic             reset_out,
  input  wire logic [31:0] monitor0,
  input  wire logic [31:0] monitor1,
  input  wire logic [31:0] monitor2,
  input  wire logic [31:0] monitor3
);
  logic        rst_s1;
  logic        rst_sync_n;
  logic [31:0] word_s2;
  logic [31:0] word_q3;
  logic [31:0] word_s3;
  logic        stb_s2;
  logic        stb_s3;
  logic        stb_level;
  logic        lead;
  logic        trail;
  logic [1:0]  block_hold;
  logic        hit_hold;
  logic [31:0] mon_sel;

  // Chip field match against the fixed address.
  function automatic logic chip_hit(input logic [31:0] w);
    return w[pcbd_pkg::CHIP_MSB:pcbd_pkg::CHIP_LSB] == pcbd_pkg::CHIP_ADDR;
  endfunction : chip_hit

  // Block field of a host word.
  function automatic logic [1:0] block_of(input logic [31:0] w);
    return w[pcbd_pkg::BLK_MSB:pcbd_pkg::BLK_LSB];
  endfunction : block_of

  // Reset release through two flops; assertion stays asynchronous.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1     <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_s1     <= 1'b1;
      rst_sync_n <= rst_s1;
    end
  end

  // The host word and strobe come from another board, so synchronise.
  // bring bus into clock domain
  pcbd_sync #(
    .W       (32),
    .RST_VAL (pcbd_pkg::WORD_RST)
  ) u_word_sync (
    .clock (clock),
    .rst_n (rst_sync_n),
    .d     (host_write_word),
    .q2    (word_s2),
    .q3    (word_q3)
  );

  // A word change counts once the last two stages agree, so a bus caught
  // in mid-change never reaches the decode; this costs one cycle.
  // settled host word
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      word_s3 <= pcbd_pkg::WORD_RST;
    else if (word_s2 == word_q3)
      word_s3 <= word_q3;
  end

  pcbd_sync #(
    .W       (1),
    .RST_VAL (1'b1)
  ) u_stb_sync (
    .clock (clock),
    .rst_n (rst_sync_n),
    .d     (host_strobe_n),
    .q2    (stb_s2),
    .q3    (stb_s3)
  );

  // A strobe change counts once the last two stages agree.
  // host word settled before strobe
  assign lead  = (stb_s2 == stb_s3) && !stb_s3 && stb_level;
  assign trail = (stb_s2 == stb_s3) && stb_s3 && !stb_level;

  // Filtered strobe level, idle high.
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      stb_level <= 1'b1;
    else if (stb_s2 == stb_s3)
      stb_level <= stb_s3;
  end

  // Address and data to the blocks are latched at the leading edge and
  // held, so a block may still look at them when the read strobe fires.
  // split host word
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      block_data <= 16'h0000;
      reg_select <= 6'h00;
      block_hold <= 2'h0;
      hit_hold   <= 1'b0;
    end
    else if (lead)
    begin
      block_data <= word_s3[pcbd_pkg::DATA_W-1:0];
      reg_select <= {2'h0, word_s3[pcbd_pkg::SUB_MSB:pcbd_pkg::SUB_LSB]};
      block_hold <= block_of(word_s3);
      hit_hold   <= chip_hit(word_s3);
    end
  end

  // Write strobe on the leading edge, one cycle, one block only.
  // write strobe pulse
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      wr_strobe <= pcbd_pkg::STB_RST;
    else if (lead && chip_hit(word_s3))
      wr_strobe <= 4'h1 << block_of(word_s3);
    else
      wr_strobe <= pcbd_pkg::STB_RST;
  end

  // Read strobe on the trailing edge, using the address held at lead.
  // read strobe pulse
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      rd_strobe <= pcbd_pkg::STB_RST;
    else if (trail && hit_hold)
      rd_strobe <= 4'h1 << block_hold;
    else
      rd_strobe <= pcbd_pkg::STB_RST;
  end

  // Readback mux follows the current address, so no read strobe is needed.
  // select addressed block
  always_comb
  begin
    case (block_of(word_s3))
      2'h0:    mon_sel = monitor0;
      2'h1:    mon_sel = monitor1;
      2'h2:    mon_sel = monitor2;
      default: mon_sel = monitor3;
    endcase
  end

  // Read bus is shared with other chips, so drive it only when addressed.
  // registered read bus
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      read_word <= pcbd_pkg::WORD_RST;
      read_oe   <= 1'b0;
    end
    else
    begin
      read_word <= mon_sel;
      read_oe   <= chip_hit(word_s3);
    end
  end

  // Reset works straight from the pins; it must act with the clock stopped.
  // combinational reset decode
  assign reset_out = chip_hit(host_write_word) &&
    (host_write_word[pcbd_pkg::REG_MSB:pcbd_pkg::REG_LSB] ==
     pcbd_pkg::LAST_REG);

  chk_wr_pulse: assert property (
    @(posedge clock) disable iff (!rst_sync_n)
    (wr_strobe != 4'h0) |=> (wr_strobe == 4'h0))
    else $error("write strobe longer than one cycle");

  chk_wr_cause: assert property (
    @(posedge clock) disable iff (!rst_sync_n)
    (wr_strobe != 4'h0) |-> $past(lead))
    else $error("write strobe without leading edge");

  chk_wr_onehot: assert property (
    @(posedge clock) disable iff (!rst_sync_n)
    $onehot0(wr_strobe) && $onehot0(rd_strobe))
    else $error("more than one block strobed");

  chk_blk_select: assert property (
    @(posedge clock) disable iff (!rst_sync_n)
    (wr_strobe != 4'h0) |-> wr_strobe[block_hold])
    else $error("write strobe to wrong block");

  chk_rd_trail: assert property (
    @(posedge clock) disable iff (!rst_sync_n)
    (rd_strobe != 4'h0) |-> ($past(trail) && stb_level)
      ##1 (rd_strobe == 4'h0))
    else $error("read strobe not a trailing pulse");

  chk_chip_match: assert property (
    @(posedge clock) disable iff (!rst_sync_n)
    (lead && !chip_hit(word_s3)) |=> (wr_strobe == 4'h0))
    else $error("strobe for another chip");

  chk_oe_release: assert property (
    @(posedge clock) disable iff (!rst_sync_n)
    !chip_hit(word_s3) |=> !read_oe)
    else $error("read bus driven while not addressed");

  chk_read_mux: assert property (
    @(posedge clock) disable iff (!rst_sync_n)
    chip_hit(word_s3) |=> (read_oe && read_word == $past(mon_sel)))
    else $error("read word not from selected block");

  chk_reset_addr: assert property (
    @(posedge clock)
    reset_out |->
      (host_write_word[pcbd_pkg::CHIP_MSB:pcbd_pkg::CHIP_LSB] ==
       pcbd_pkg::CHIP_ADDR))
    else $error("reset raised for another chip");
endmodule : pcbd_top

/* File: hw/pcbd_pkg.sv */
// Constants shared by the parallel control bus decoder.
package pcbd_pkg;
  // Host word layout: chip field, register field, write value.
  localparam int          WORD_W      = 32;
  localparam int          DATA_W      = 16;
  localparam int          CHIP_W      = 5;
  localparam int          CHIP_MSB    = 31;
  localparam int          CHIP_LSB    = 27;
  localparam int          REG_W       = 6;
  localparam int          REG_MSB     = 26;
  localparam int          REG_LSB     = 21;
  localparam int          BLK_MSB     = 26;
  localparam int          BLK_LSB     = 25;
  localparam int          SUB_MSB     = 24;
  localparam int          SUB_LSB     = 21;
  localparam int          NUM_BLOCKS  = 4;
  localparam int          BLK_W       = 2;
  localparam int          SUB_W       = 4;
  // Fixed chip address, set at design time (value is arbitrary).
  localparam logic [4:0]  CHIP_ADDR   = 5'h01;
  // Last register of the chip space raises the reset output.
  localparam logic [5:0]  LAST_REG    = 6'h3f;
  // Reset values.
  localparam logic [31:0] WORD_RST    = 32'h0000_0000;
  localparam logic [3:0]  STB_RST     = 4'h0;
endpackage : pcbd_pkg

/* File: hw/pcbd_sync.sv */
// Three-stage synchroniser for pins entering the clock domain.
`timescale 1ns/100ps
module pcbd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q2,
  output logic      [W-1:0] q3
);
  logic [W-1:0] q1;

  // The first stage feeds only the second; q2 and q3 are compared outside.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q1 <= RST_VAL;
      q2 <= RST_VAL;
      q3 <= RST_VAL;
    end
    else
    begin
      q1 <= d;
      q2 <= q1;
      q3 <= q2;
    end
  end
endmodule : pcbd_sync

/* File: bench/pcbd_host.sv */
// Host model that drives the control word and strobe and reads the bus.
`timescale 1ns/100ps
module pcbd_host (
  input  wire logic        clock,
  input  wire logic [31:0] read_word,
  input  wire logic        read_oe,
  output logic      [31:0] host_write_word,
  output logic             host_strobe_n
);
  int          cyc;
  int          fall_cyc;
  int          rise_cyc;
  logic [31:0] last_bus;
  logic [31:0] bus;
  logic [31:0] rd_data;
  logic        oe_seen;
  // Edge counter, so that strobe answers can be timed against the pin.
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
  end
  // A released bus shows the inverse of its last value, so stale data fails.
  // shared read lines
  always @(posedge clock)
  begin
    if (read_oe)
      last_bus <= read_word;
  end
  assign bus = read_oe ? read_word : ~last_bus;
  // Idle host: word cleared and strobe high.
  initial
  begin
    cyc = 0;
    last_bus = '0;
    host_write_word = '0;
    host_strobe_n = 1'b1;
  end
  // One access: word first, then a low strobe; data read just before rising.
  // word then strobe
  task automatic access(input logic [31:0] w);
    @(posedge clock);
    #2;
    host_write_word = w;
    repeat (3) @(posedge clock);
    #2;
    host_strobe_n = 1'b0;
    fall_cyc = cyc;
    repeat (4) @(posedge clock);
    #2;
    rd_data = bus;
    oe_seen = read_oe;
    host_strobe_n = 1'b1;
    rise_cyc = cyc;
    repeat (6) @(posedge clock);
    #2;
  endtask : access
endmodule : pcbd_host

/* File: bench/pcbd_top_test.sv */
// Self-checking bench for the control bus decoder.
`timescale 1ns/100ps
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: %s", $time, m); end end
module pcbd_top_test;
  logic        clock;
  logic        rst_n;
  logic [31:0] read_word;
  logic        read_oe;
  logic [3:0]  wr_strobe;
  logic [3:0]  rd_strobe;
  logic [15:0] block_data;
  logic [5:0]  reg_select;
  logic        reset_out;
  logic [31:0] host_write_word;
  logic        host_strobe_n;
  logic [31:0] mon [4];
  logic [3:0]  wr_val;
  logic [3:0]  rd_val;
  int          wr_n;
  int          rd_n;
  int          wr_at;
  int          rd_at;
  int          n_fail;
  int          comparisons;
  int          tick;
  pcbd_top u_dut (.clock(clock), .rst_n(rst_n),
    .host_write_word(host_write_word), .host_strobe_n(host_strobe_n),
    .read_word(read_word), .read_oe(read_oe), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .block_data(block_data),
    .reg_select(reg_select), .reset_out(reset_out), .monitor0(mon[0]),
    .monitor1(mon[1]), .monitor2(mon[2]), .monitor3(mon[3]));
  pcbd_host u_host (.clock(clock), .read_word(read_word),
    .read_oe(read_oe), .host_write_word(host_write_word),
    .host_strobe_n(host_strobe_n));
  // Clock at 50 MHz.
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Strobe watcher: counts pulse cycles and notes when they were seen.
  always @(posedge clock)
  begin
    tick++;
    if (|wr_strobe)
    begin
      wr_n++;
      wr_val = wr_strobe;
      wr_at = u_host.cyc;
    end
    if (|rd_strobe)
    begin
      rd_n++;
      rd_val = rd_strobe;
      rd_at = u_host.cyc;
    end
    if (tick == 2000)
    begin
      n_fail++;
      end_sim();
    end
  end
  // Build a host word from chip, block, sub-register and value.
  function automatic logic [31:0] word(input logic [4:0] chip,
    input logic [1:0] blk, input logic [3:0] sub, input logic [15:0] v);
    return {chip, blk, sub, 5'h00, v};
  endfunction : word
  // Access to the own chip: one strobe each, right block, right timing.
  task automatic t_own(input logic [1:0] blk, input logic [3:0] sub,
    input logic [15:0] v);
    wr_n = 0;
    rd_n = 0;
    u_host.access(word(pcbd_pkg::CHIP_ADDR, blk, sub, v));
    `CHK(wr_n, 1, "write pulse count")
    `CHK(wr_val, 4'h1 << blk, "write block")
    `CHK(wr_at, u_host.fall_cyc + 4, "write timing")
    `CHK(rd_n, 1, "read pulse count")
    `CHK(rd_val, 4'h1 << blk, "read block")
    `CHK(rd_at, u_host.rise_cyc + 4, "read timing")
    `CHK(block_data, v, "block data")
    `CHK(reg_select, {2'b00, sub}, "register select")
    `CHK(u_host.oe_seen, 1'b1, "bus driven")
    `CHK(u_host.rd_data, mon[blk], "readback")
  endtask : t_own
  // Access to another chip: no strobes and the bus stays released.
  task automatic t_other(input logic [4:0] chip);
    wr_n = 0;
    rd_n = 0;
    u_host.access(word(chip, 2'h2, 4'h5, 16'h1234));
    `CHK(wr_n + rd_n, 0, "foreign strobes")
    `CHK(u_host.oe_seen, 1'b0, "foreign bus")
  endtask : t_other
  // Last register raises reset at once, without any clock edge.
  task automatic t_reset(input logic [4:0] chip, input logic exp);
    @(posedge clock);
    #2;
    u_host.host_write_word = word(chip, 2'h3, 4'hf, 16'h0000);
    #1;
    `CHK(reset_out, exp, "reset output")
    @(posedge clock);
    #2;
    u_host.host_write_word = '0;
    #1;
    `CHK(reset_out, 1'b0, "reset release")
  endtask : t_reset
  // Reset in mid-run: outputs drop at once and the next access recovers.
  task automatic t_rst_mid();
    @(posedge clock);
    #2;
    rst_n = 1'b0;
    #1;
    `CHK(read_oe, 1'b0, "reset bus release")
    `CHK(wr_strobe | rd_strobe, 4'h0, "reset strobes")
    `CHK(block_data, 16'h0000, "reset data")
    repeat (2) @(posedge clock);
    #2;
    rst_n = 1'b1;
    repeat (4) @(posedge clock);
  endtask : t_rst_mid
  // Verdict and end of run.
  task automatic end_sim();
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // Main sequence.
  initial
  begin
    for (int i = 0; i < 4; i++)
      mon[i] = 32'hf0e1_d2c3 + 32'(i) * 32'h0101_0101;
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    #2;
    rst_n = 1'b1;
    repeat (4) @(posedge clock);
    for (int b = 0; b < 4; b++)
      t_own(2'(b), 4'(b * 5), (b % 2) ? 16'hffff : 16'h0000);
    t_own(2'h3, 4'hf, 16'h8001);
    t_other(pcbd_pkg::CHIP_ADDR ^ 5'h10);
    t_rst_mid();
    t_own(2'h1, 4'h1, 16'h00ff);
    t_reset(pcbd_pkg::CHIP_ADDR, 1'b1);
    t_reset(pcbd_pkg::CHIP_ADDR ^ 5'h01, 1'b0);
    end_sim();
  end
endmodule : pcbd_top_test
